// ==== rtl/egti_tx_overhead.sv ====
// e3 g.832 transmit overhead generation and insertion with wishbone registers
`timescale 1ns/10ps
`include "egti_regs.svh"

// What this block does
// - seven overhead octets sent in each frame
// - data-select one takes all overhead from data
// - internal alignment octets f6 then 28, msb first
// - framing pin select takes alignment from pin
// - em octet is even bip-8 of previous frame
// - trail trace from pin, else all zeros
// - auto defect sends los or oof in bit1
// - auto off, pin select: defect bit from pin
// - force defect sends one, overriding auto and pin
// - bit2 error indication: pin or automatic
// - received bip mismatch sends one for one frame
// - bits3-5 payload type, applies next frame
// - sync mode: bits6-7 multiframe, internal or pin
// - two-bit wrapping counter, cleared on auto enable
// - normal mode: bits6-7 from pin or register
// - bit8 timing marker, or message bit by mi
// - three-bit select, only one uses buffer
// - network octet from pin, ones, or buffer
// - general octet from pin, ones, or buffer
module egti_tx_overhead #(
  parameter int FRAME_OCTETS = `EGTI_FRAME_OCTETS
) (
  input wire logic clk,
  input wire logic rst_n,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // line side
  input wire logic lineBitEn,
  output logic txBit,
  output logic txBitValid,
  output logic txFrameStart,
  // system payload stream
  output logic sysDataReq,
  input wire logic sysDataBit,
  // serial overhead pin
  input wire logic overheadSerialInput,
  output logic overheadPinUse,
  // internal data-link buffer
  input wire logic [7:0] dlByte,
  output logic dlTake,
  // receiver status
  input wire egti_pkg::egti_rxstat_t rxStatus
);
  import egti_pkg::*;

  if (FRAME_OCTETS <= int'(`EGTI_POS_GC) || FRAME_OCTETS > 1023) begin : g_bad_frame
    $error("egti_tx_overhead: frame length cannot hold the overhead octets");
  end

  localparam logic [9:0] LAST_OCTET = 10'(FRAME_OCTETS - 1);
  // alignment patterns held as vectors so each bit is picked, not shifted and cut
  localparam logic [7:0] FA1_PAT = `EGTI_FA1;
  localparam logic [7:0] FA2_PAT = `EGTI_FA2;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  egti_ctrl_t ctrl_r;
  egti_field_t field_r;
  logic [31:0] dlMap_r;
  logic wbAck_r;
  logic [31:0] wbDat_r;
  logic [31:0] statusWord;
  logic wbReq;
  logic [31:0] ctrlWord;
  logic [31:0] fieldWord;
  logic [31:0] ctrlNxt;
  logic [31:0] fieldNxt;
  logic [31:0] dlMapNxt;

  assign wbReq = wb_cyc_i & wb_stb_i & ~wbAck_r;
  assign ctrlWord = {20'h00000, ctrl_r};
  assign fieldWord = {23'h000000, field_r};

  // byte lane merge per lane
  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    assign ctrlNxt[lane*8 +: 8] = wb_sel_i[lane] ? wb_dat_i[lane*8 +: 8] : ctrlWord[lane*8 +: 8];
    assign fieldNxt[lane*8 +: 8] = wb_sel_i[lane] ? wb_dat_i[lane*8 +: 8]
                                                  : fieldWord[lane*8 +: 8];
    assign dlMapNxt[lane*8 +: 8] = wb_sel_i[lane] ? wb_dat_i[lane*8 +: 8] : dlMap_r[lane*8 +: 8];
  end

  // writes land on the ack edge; unmapped offsets are acked and ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= egti_ctrl_t'(`EGTI_CTRL_RST);
      field_r <= egti_field_t'(`EGTI_FIELD_RST);
      dlMap_r <= `EGTI_DLMAP_RST;
    end else if (wbReq && wb_we_i) begin
      case (wb_adr_i)
        `EGTI_OFF_CTRL: ctrl_r <= egti_ctrl_t'(ctrlNxt[`EGTI_CTRL_W-1:0]);
        `EGTI_OFF_FIELD: field_r <= egti_field_t'(fieldNxt[`EGTI_FIELD_W-1:0]);
        `EGTI_OFF_DLMAP: dlMap_r <= dlMapNxt;
        default: ;
      endcase
    end
  end

  // one wait state: ack registered, dropped the cycle after
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wbAck_r <= 1'b0;
      wbDat_r <= 32'h00000000;
    end else begin
      wbAck_r <= wbReq;
      case (wb_adr_i)
        `EGTI_OFF_CTRL: wbDat_r <= ctrlWord;
        `EGTI_OFF_FIELD: wbDat_r <= fieldWord;
        `EGTI_OFF_DLMAP: wbDat_r <= dlMap_r;
        `EGTI_OFF_STATUS: wbDat_r <= statusWord;
        default: wbDat_r <= 32'h00000000;
      endcase
    end
  end

  assign wb_ack_o = wbAck_r;
  assign wb_dat_o = wbDat_r;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  logic pinMeta_r;
  logic pinSync_r;

  // only the second stage is ever read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_r <= 1'b0;
      pinSync_r <= 1'b0;
    end else begin
      pinMeta_r <= overheadSerialInput;
      pinSync_r <= pinMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame position

  logic [2:0] bitCnt_r;
  logic [9:0] octCnt_r;
  logic lastBit;
  logic frameEnd;
  egti_oct_t octKind;

  assign lastBit = lineBitEn && (bitCnt_r == `EGTI_LAST_BIT);
  assign frameEnd = lastBit && (octCnt_r == LAST_OCTET);

  // bit and octet counters step on the line bit enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_r <= 3'h0;
      octCnt_r <= 10'h000;
    end else if (lineBitEn) begin
      bitCnt_r <= bitCnt_r + 3'h1;
      if (lastBit) begin
        octCnt_r <= frameEnd ? 10'h000 : octCnt_r + 10'h001;
      end
    end
  end

  // octet classification, seven overhead slots per frame
  always_comb begin
    case (octCnt_r)
      `EGTI_POS_FA1: octKind = EGTI_OCT_FA1;
      `EGTI_POS_FA2: octKind = EGTI_OCT_FA2;
      `EGTI_POS_EM: octKind = EGTI_OCT_EM;
      `EGTI_POS_TR: octKind = EGTI_OCT_TR;
      `EGTI_POS_MA: octKind = EGTI_OCT_MA;
      `EGTI_POS_NR: octKind = EGTI_OCT_NR;
      `EGTI_POS_GC: octKind = EGTI_OCT_GC;
      default: octKind = EGTI_OCT_PAYLOAD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-frame state

  egti_field_t frameField_r;
  logic [7:0] bipAcc_r;
  logic [7:0] bipLast_r;
  logic reiPend_r;
  logic reiSend_r;
  logic [1:0] miCnt_r;
  logic miAuto_r;
  logic miHi_r;
  logic miLo_r;
  logic curBit;
  logic miAutoNow;

  assign miAutoNow = ctrl_r.syncStatusModeEn & ~ctrl_r.multiframePinSel;

  // register fields frozen at frame start so a write lands in the next frame, except ssmMsg bit 0, read from the live field_r
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frameField_r <= egti_field_t'(`EGTI_FIELD_RST);
    end else if (frameEnd) begin
      frameField_r <= field_r;
    end
  end

  // bip-8 over every sent bit, overhead included, handed on at frame end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bipAcc_r <= 8'h00;
      bipLast_r <= 8'h00;
    end else if (lineBitEn) begin
      if (frameEnd) begin
        bipLast_r <= bipAcc_r ^ (8'(curBit) << (3'h7 - bitCnt_r));
        bipAcc_r <= 8'h00;
      end else begin
        bipAcc_r <= bipAcc_r ^ (8'(curBit) << (3'h7 - bitCnt_r));
      end
    end
  end

  // a mismatch arriving as the pending flag is consumed still counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reiPend_r <= 1'b0;
      reiSend_r <= 1'b0;
    end else begin
      if (frameEnd) begin
        reiSend_r <= reiPend_r | rxStatus.bipMismatch;
      end
      if (rxStatus.bipMismatch) begin
        reiPend_r <= ~frameEnd;
      end else if (frameEnd) begin
        reiPend_r <= 1'b0;
      end
    end
  end

  // multiframe counter, restarts at 00 when automatic mode is switched on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miCnt_r <= 2'h0;
      miAuto_r <= 1'b0;
    end else begin
      miAuto_r <= miAutoNow;
      if (miAutoNow && !miAuto_r) begin
        miCnt_r <= 2'h0;
      end else if (frameEnd) begin
        miCnt_r <= miCnt_r + 2'h1;
      end
    end
  end

  // capture the mi bits actually sent; they pick the message bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miHi_r <= 1'b0;
      miLo_r <= 1'b0;
    end else if (lineBitEn && octKind == EGTI_OCT_MA) begin
      if (bitCnt_r == `EGTI_MA_MI_HI) begin
        miHi_r <= curBit;
      end
      if (bitCnt_r == `EGTI_MA_MI_LO) begin
        miLo_r <= curBit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link channel sources

  egti_src_t nrSrc;
  egti_src_t gcSrc;
  logic [3:0] mapEntry;

  // table lookup; buffer on both would clash, so the general octet yields
  always_comb begin
    mapEntry = dlMap_r[{ctrl_r.linkChannelSourceSel, 2'b00} +: 4];
    nrSrc = egti_src_t'(mapEntry[1:0]);
    gcSrc = egti_src_t'(mapEntry[3:2]);
    if (nrSrc == EGTI_SRC_BUF && gcSrc == EGTI_SRC_BUF) begin
      gcSrc = EGTI_SRC_ONES;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit selection

  logic usePin;
  logic useSys;
  logic useBuf;
  logic [7:0] maByte;
  logic [1:0] miSent;
  logic [3:0] ssmMsg;
  logic rdiBit;
  logic faByteBit;

  // remote defect: force beats automatic beats pin
  always_comb begin
    if (ctrl_r.forceRemoteDefect) begin
      rdiBit = 1'b1;
    end else if (ctrl_r.autoRemoteDefectEn) begin
      rdiBit = rxStatus.lossOfSignal | rxStatus.outOfFrame;
    end else if (ctrl_r.remoteDefectPinSel) begin
      rdiBit = pinSync_r;
    end else begin
      rdiBit = 1'b0;
    end
  end

  // maintenance octet, first sent bit in the msb
  always_comb begin
    ssmMsg = {frameField_r.syncStatusMsgUpper[2:0], field_r.timingMarkerMsgBit1};
    miSent = {miHi_r, miLo_r};
    maByte[7] = rdiBit;
    maByte[6] = ctrl_r.remoteErrorPinSel ? pinSync_r : reiSend_r;
    maByte[5:3] = frameField_r.payloadTypeField;
    if (ctrl_r.multiframePinSel) begin
      maByte[2:1] = {pinSync_r, pinSync_r};
    end else if (ctrl_r.syncStatusModeEn) begin
      maByte[2:1] = miCnt_r;
    end else begin
      maByte[1] = frameField_r.payloadDependentValue[0];
      maByte[2] = frameField_r.payloadDependentValue[1];
    end
    if (ctrl_r.syncStatusModeEn) begin
      maByte[0] = ssmMsg[miSent];
    end else begin
      maByte[0] = frameField_r.timingMarkerMsgBit1;
    end
  end

  // per-octet source; the pin or buffer carries a whole octet serially, but the pin gives only chosen bits of the maintenance octet
  always_comb begin
    usePin = 1'b0;
    useBuf = 1'b0;
    useSys = 1'b0;
    faByteBit = 1'b0;
    curBit = 1'b0;
    if (ctrl_r.overheadWithDataSel || octKind == EGTI_OCT_PAYLOAD) begin
      useSys = 1'b1;
      curBit = sysDataBit;
    end else begin
      case (octKind)
        EGTI_OCT_FA1, EGTI_OCT_FA2: begin
          faByteBit = (octKind == EGTI_OCT_FA1) ? FA1_PAT[3'h7 - bitCnt_r]
                                                : FA2_PAT[3'h7 - bitCnt_r];
          usePin = ctrl_r.framingPinSel;
          curBit = ctrl_r.framingPinSel ? pinSync_r : faByteBit;
        end
        EGTI_OCT_EM: curBit = bipLast_r[3'h7 - bitCnt_r];
        EGTI_OCT_TR: begin
          usePin = ctrl_r.trailTracePinSel;
          curBit = ctrl_r.trailTracePinSel & pinSync_r;
        end
        EGTI_OCT_MA: begin
          usePin = (bitCnt_r == 3'h0 && !ctrl_r.forceRemoteDefect
                    && !ctrl_r.autoRemoteDefectEn && ctrl_r.remoteDefectPinSel)
                   || (bitCnt_r == 3'h1 && ctrl_r.remoteErrorPinSel)
                   || ((bitCnt_r == `EGTI_MA_MI_HI || bitCnt_r == `EGTI_MA_MI_LO)
                       && ctrl_r.multiframePinSel);
          if (ctrl_r.multiframePinSel && (bitCnt_r == `EGTI_MA_MI_HI
                                          || bitCnt_r == `EGTI_MA_MI_LO)) begin
            curBit = pinSync_r;
          end else begin
            curBit = maByte[3'h7 - bitCnt_r];
          end
        end
        EGTI_OCT_NR, EGTI_OCT_GC: begin
          case ((octKind == EGTI_OCT_NR) ? nrSrc : gcSrc)
            EGTI_SRC_PIN: begin
              usePin = 1'b1;
              curBit = pinSync_r;
            end
            EGTI_SRC_BUF: begin
              useBuf = 1'b1;
              curBit = dlByte[3'h7 - bitCnt_r];
            end
            default: curBit = 1'b1;
          endcase
        end
        default: curBit = sysDataBit;
      endcase
    end
  end

  assign sysDataReq = lineBitEn & useSys;
  assign overheadPinUse = usePin;
  assign dlTake = lastBit & useBuf;

  ////////////////////////////////////////////////////////////////////////////
  // line output

  // data outputs registered; valid marks each new bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBit <= 1'b0;
      txBitValid <= 1'b0;
      txFrameStart <= 1'b0;
    end else begin
      txBitValid <= lineBitEn;
      txFrameStart <= lineBitEn && octCnt_r == 10'h000 && bitCnt_r == 3'h0;
      if (lineBitEn) begin
        txBit <= curBit;
      end
    end
  end

  // status: last bip, error flags, multiframe count
  assign statusWord = {19'h00000, miCnt_r, reiSend_r, reiPend_r, bipLast_r};

endmodule : egti_tx_overhead

// ==== rtl/egti_regs.svh ====
// register offsets, reset values, frame positions and maintenance bit positions
`ifndef EGTI_REGS_SVH
`define EGTI_REGS_SVH

// register byte offsets on the wishbone slave
`define EGTI_OFF_CTRL 4'h0
`define EGTI_OFF_FIELD 4'h4
`define EGTI_OFF_DLMAP 4'h8
`define EGTI_OFF_STATUS 4'hc

// reset values
`define EGTI_CTRL_RST 12'h000
`define EGTI_FIELD_RST 9'h000
`define EGTI_DLMAP_RST 32'h1114_0415

// register field widths
`define EGTI_CTRL_W 12
`define EGTI_FIELD_W 9

// alignment patterns, sent msb first
`define EGTI_FA1 8'hf6
`define EGTI_FA2 8'h28

// frame geometry, in octets from frame start
`define EGTI_FRAME_OCTETS 537
`define EGTI_POS_FA1 10'h000
`define EGTI_POS_FA2 10'h001
`define EGTI_POS_EM 10'h03b
`define EGTI_POS_TR 10'h076
`define EGTI_POS_MA 10'h0b1
`define EGTI_POS_NR 10'h0ec
`define EGTI_POS_GC 10'h127

// bit positions inside the maintenance octet (0 = first sent)
`define EGTI_MA_MI_HI 3'h5
`define EGTI_MA_MI_LO 3'h6
`define EGTI_LAST_BIT 3'h7

`endif

// ==== rtl/egti_pkg.sv ====
// types shared by the overhead inserter
package egti_pkg;

  // transmit control word
  typedef struct packed {
    logic [2:0] linkChannelSourceSel;
    logic multiframePinSel;
    logic syncStatusModeEn;
    logic remoteErrorPinSel;
    logic forceRemoteDefect;
    logic remoteDefectPinSel;
    logic autoRemoteDefectEn;
    logic trailTracePinSel;
    logic framingPinSel;
    logic overheadWithDataSel;
  } egti_ctrl_t;

  // maintenance octet content fields
  typedef struct packed {
    logic [2:0] syncStatusMsgUpper;
    logic timingMarkerMsgBit1;
    logic [1:0] payloadDependentValue;
    logic [2:0] payloadTypeField;
  } egti_field_t;

  // source of a link channel octet
  typedef enum logic [1:0] {
    EGTI_SRC_PIN,
    EGTI_SRC_ONES,
    EGTI_SRC_BUF,
    EGTI_SRC_SPARE
  } egti_src_t;

  // which octet of the frame is on the line
  typedef enum logic [2:0] {
    EGTI_OCT_FA1,
    EGTI_OCT_FA2,
    EGTI_OCT_EM,
    EGTI_OCT_TR,
    EGTI_OCT_MA,
    EGTI_OCT_NR,
    EGTI_OCT_GC,
    EGTI_OCT_PAYLOAD
  } egti_oct_t;

  // receiver status carried in
  typedef struct packed {
    logic lossOfSignal;
    logic outOfFrame;
    logic bipMismatch;
  } egti_rxstat_t;

endpackage : egti_pkg

// ==== dv/egti_tx_overhead_chk.sv ====
// port assertions for the overhead inserter
`timescale 1ns/10ps
`include "egti_regs.svh"
module egti_tx_overhead_chk
  import egti_pkg::*;
#(
  parameter int FRAME_OCTETS = 537
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic lineBitEn,
  input wire logic txBit,
  input wire logic txBitValid,
  input wire logic txFrameStart,
  input wire logic sysDataReq,
  input wire logic overheadPinUse,
  input wire logic dlTake
);
  localparam logic [15:0] FAW = {`EGTI_FA1, `EGTI_FA2};
  egti_ctrl_t ctl, ctl1, ctl2;
  int bitCnt;
  logic seen;
  logic st;
  //////////////////////////////////////////////////////////////////////////////
  // control shadow, written on the acked edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ctl <= '0;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 4'h0) begin
      if (wb_sel_i[0]) ctl[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) ctl[11:8] <= wb_dat_i[11:8];
    end
  end
  // history per frame: a setting is trusted only once two frame starts saw it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl1 <= '0;
      ctl2 <= '0;
    end else if (txFrameStart) begin
      ctl1 <= ctl;
      ctl2 <= ctl1;
    end
  end
  assign st = ctl == ctl1 && ctl1 == ctl2;
  // bit index inside the frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt <= 0;
      seen <= 1'h0;
    end else if (txFrameStart) begin
      bitCnt <= 1;
      seen <= 1'h1;
    end else if (txBitValid) bitCnt <= bitCnt + 1;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack not one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  chk_valid_lag: assert property (lineBitEn |=> txBitValid)
    else $error("line bit not answered next cycle");
  chk_bit_hold: assert property (!lineBitEn |=> !txBitValid && $stable(txBit))
    else $error("line bit moved without enable");
  chk_start_valid: assert property (txFrameStart |-> txBitValid)
    else $error("frame start without a valid bit");
  chk_req_gated: assert property (sysDataReq || dlTake |-> lineBitEn)
    else $error("stream request without line enable");
  chk_frame_len: assert property (txFrameStart && seen |-> bitCnt == FRAME_OCTETS * 8)
    else $error("frame length wrong");
  chk_data_all: assert property (lineBitEn && st && ctl.overheadWithDataSel |->
    sysDataReq && !overheadPinUse)
    else $error("bit not taken from data stream");
  chk_fa_first: assert property (txFrameStart && st && !ctl.overheadWithDataSel &&
    !ctl.framingPinSel |-> txBit)
    else $error("first alignment bit not one");
  chk_fa_pattern: assert property (txBitValid && !txFrameStart && seen && st &&
    !ctl.overheadWithDataSel && !ctl.framingPinSel && bitCnt < 16 |->
    txBit == FAW[4'(15 - bitCnt)])
    else $error("alignment pattern wrong");
  chk_tr_zero: assert property (txBitValid && seen && st && !ctl.overheadWithDataSel &&
    !ctl.trailTracePinSel && bitCnt / 8 == `EGTI_POS_TR |-> !txBit)
    else $error("trail trace bit not zero");
  cover property (txFrameStart && st && ctl.overheadWithDataSel);
  cover property (dlTake);
  cover property (overheadPinUse && lineBitEn);
endmodule : egti_tx_overhead_chk

bind egti_tx_overhead egti_tx_overhead_chk #(.FRAME_OCTETS(FRAME_OCTETS)) chk (.clk, .rst_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .lineBitEn,
  .txBit, .txBitValid, .txFrameStart, .sysDataReq, .overheadPinUse, .dlTake);

// ==== dv/egti_line_model.sv ====
// line unit model: clocks bits out and gathers each frame's overhead octets
`timescale 1ns/10ps
`include "egti_regs.svh"
module egti_line_model #(
  parameter int FRAME_OCTETS = 537
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic txBit,
  input wire logic txBitValid,
  input wire logic txFrameStart,
  output logic lineBitEn,
  output logic [7:0] oh [7],
  output logic [7:0] emExp,
  output int frameCnt
);
  localparam int POS [7] = '{`EGTI_POS_FA1, `EGTI_POS_FA2, `EGTI_POS_EM, `EGTI_POS_TR,
    `EGTI_POS_MA, `EGTI_POS_NR, `EGTI_POS_GC};
  logic [7:0] sh, acc, bipPrev;
  logic [7:0] cur [7];
  int pos;
  logic run;
  //////////////////////////////////////////////////////////////////////////////
  // bit enable every cycle, or every other one on a slow line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lineBitEn <= 1'h0;
    else lineBitEn <= slow ? ~lineBitEn : 1'h1;
  end
  // msb-first octets; parity runs over every bit, so it is published a frame late
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run = 1'h0;
      frameCnt = 0;
      acc = 8'h00;
      bipPrev = 8'h00;
    end else if (txBitValid && (run || txFrameStart)) begin
      if (txFrameStart) pos = 0;
      run = 1'h1;
      sh = {sh[6:0], txBit};
      if (pos % 8 == 7) begin
        acc = acc ^ sh;
        for (int k = 0; k < 7; k++) if (POS[k] == pos / 8) cur[k] = sh;
        if (pos / 8 == FRAME_OCTETS - 1) begin
          oh = cur;
          emExp = bipPrev;
          bipPrev = acc;
          acc = 8'h00;
          frameCnt++;
        end
      end
      pos++;
    end
  end
endmodule : egti_line_model

// ==== dv/test_egti_tx_overhead.sv ====
// self-checking bench for the overhead inserter
`timescale 1ns/10ps
`include "egti_regs.svh"
module test_egti_tx_overhead;
  import egti_pkg::*;
  localparam int FO = 297;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rdq;
  logic wb_ack_o, lineBitEn, txBit, txBitValid, txFrameStart, sysDataReq, overheadPinUse, dlTake;
  logic sysDataBit = 1'h0;
  logic overheadSerialInput = 1'h0;
  logic [7:0] dlByte = 8'h5a;
  egti_rxstat_t rxStatus = '0;
  logic slow = 1'h0;
  logic dataZero = 1'h0;
  logic [7:0] oh [7];
  logic [7:0] emExp;
  logic [1:0] mi;
  int frameCnt;
  int errorCnt = 0;
  int nTests = 0;
  egti_tx_overhead #(.FRAME_OCTETS(FO)) dut (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .lineBitEn, .txBit, .txBitValid,
    .txFrameStart, .sysDataReq, .sysDataBit, .overheadSerialInput, .overheadPinUse, .dlByte,
    .dlTake, .rxStatus);
  egti_line_model #(.FRAME_OCTETS(FO)) liu (.clk, .rst_n, .slow, .txBit, .txBitValid,
    .txFrameStart, .lineBitEn, .oh, .emExp, .frameCnt);
  always #12.5 clk = ~clk;
  // payload alternates so parity sees both levels; zeros when overhead rides along
  always @(posedge clk) sysDataBit <= dataZero ? 1'h0 : ~sysDataBit;
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    if (errorCnt == 0 && nTests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
    input logic [31:0] d);
    int i;
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wb_ack_o !== 1'h1 && i < 20);
    rdq = wb_dat_o;
    check(32'(wb_ack_o), 32'h1);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask : wb
  task automatic frames(input int n);
    int c, i;
    repeat (n) begin
      c = frameCnt;
      i = 0;
      while (frameCnt == c && i < 12000) begin
        @(posedge clk);
        #1;
        i++;
      end
    end
  endtask : frames
  task automatic rst;
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
  endtask : rst
  // expected link octet; a second buffer claim falls back to ones
  function automatic logic [7:0] lv(input logic [1:0] s, input logic taken);
    case (s)
      2'h0: return 8'h00;
      2'h2: return taken ? 8'hff : dlByte;
      default: return 8'hff;
    endcase
  endfunction : lv
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rst;
    wb(1'h0, `EGTI_OFF_CTRL, 4'hf, 32'h0);
    check(rdq, `EGTI_CTRL_RST);
    wb(1'h0, `EGTI_OFF_DLMAP, 4'hf, 32'h0);
    check(rdq, `EGTI_DLMAP_RST);
    wb(1'h1, `EGTI_OFF_FIELD, 4'h1, 32'hffff_ffff);
    wb(1'h0, `EGTI_OFF_FIELD, 4'hf, 32'h0);
    check(rdq, 32'hff);
  endtask : t_regs
  task automatic t_default;
    rst;
    frames(2);
    check(oh[0], `EGTI_FA1);
    check(oh[1], `EGTI_FA2);
    check(oh[2], emExp);
    check(oh[3], 8'h00);
    check(oh[4], 8'h00);
    check(oh[5], 8'hff);
    check(oh[6], 8'hff);
  endtask : t_default
  task automatic t_field;
    rst;
    frames(1);
    wb(1'h1, `EGTI_OFF_FIELD, 4'hf, 32'h35);
    rxStatus.bipMismatch <= 1'h1;
    @(posedge clk);
    rxStatus.bipMismatch <= 1'h0;
    frames(2);
    check(oh[4], 8'h6d);
    frames(1);
    check(oh[4], 8'h2d);
  endtask : t_field
  task automatic t_rdi;
    rst;
    wb(1'h1, `EGTI_OFF_CTRL, 4'hf, 32'h8);
    rxStatus.lossOfSignal <= 1'h1;
    frames(2);
    check(oh[4], 8'h80);
    rxStatus <= 3'h2;
    frames(2);
    check(oh[4], 8'h80);
    rxStatus <= 3'h0;
    frames(2);
    check(oh[4], 8'h00);
    wb(1'h1, `EGTI_OFF_CTRL, 4'hf, 32'h28);
    frames(2);
    check(oh[4], 8'h80);
  endtask : t_rdi
  task automatic t_ssm;
    rst;
    wb(1'h1, `EGTI_OFF_FIELD, 4'hf, 32'h140);
    wb(1'h1, `EGTI_OFF_CTRL, 4'hf, 32'h80);
    frames(2);
    mi = oh[4][2:1];
    repeat (3) begin
      frames(1);
      check(oh[4][2:1], 2'(mi + 2'h1));
      mi = oh[4][2:1];
      check(oh[4][0], 4'ha >> mi & 4'h1);
    end
  endtask : t_ssm
  // slow line; pin high supplies alignment, trace and the pin-sourced status bits
  task automatic t_pin;
    rst;
    slow <= 1'h1;
    overheadSerialInput <= 1'h1;
    wb(1'h1, `EGTI_OFF_CTRL, 4'hf, 32'h156);
    frames(2);
    check(oh[0], 8'hff);
    check(oh[1], 8'hff);
    check(oh[2], emExp);
    check(oh[3], 8'hff);
    check(oh[4], 8'hc6);
    slow <= 1'h0;
    overheadSerialInput <= 1'h0;
  endtask : t_pin
  task automatic t_link;
    logic [3:0] n;
    rst;
    wb(1'h1, `EGTI_OFF_DLMAP, 4'hf, 32'hba98_3210);
    for (int k = 0; k < 8; k++) begin
      n = 4'(k + (k > 3 ? 4 : 0));
      wb(1'h1, `EGTI_OFF_CTRL, 4'hf, 32'(k) << 9);
      frames(1);
      check(oh[5], lv(n[1:0], 1'h0));
      check(oh[6], lv(n[3:2], n[1:0] == 2'h2));
    end
  endtask : t_link
  task automatic t_data;
    rst;
    dataZero <= 1'h1;
    wb(1'h1, `EGTI_OFF_CTRL, 4'hf, 32'h1);
    frames(2);
    for (int k = 0; k < 7; k++) check(oh[k], 8'h00);
    dataZero <= 1'h0;
  endtask : t_data
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    t_regs;
    t_default;
    t_field;
    t_rdi;
    t_ssm;
    t_pin;
    t_link;
    t_data;
    summarize;
  end
  // hang guard, a margin beyond the longest run
  initial begin
    repeat (95000) @(posedge clk);
    errorCnt++;
    summarize;
  end
endmodule : test_egti_tx_overhead
